//--- hw/scp_pkg.sv
// Shared constants and types for the clock and power source-select unit
package scp_pkg;
  // Device register indices on the link register port
  localparam logic [7:0] DAC_SYNC_IDX = 8'h19;
  localparam logic [7:0] TIMER_A_SEL_IDX = 8'h1a;
  localparam logic [7:0] CLK_EN_IDX = 8'h1b;
  localparam logic [7:0] STOP_DIS_IDX = 8'h1c;
  localparam logic [7:0] HS_SEL_IDX = 8'h1d;
  localparam logic [7:0] STATUS_IDX = 8'h1e;
  // Writable-bit masks; reserved bits stay zero
  localparam logic [15:0] DAC_SYNC_MASK = 16'h0077;
  localparam logic [15:0] TIMER_A_SEL_MASK = 16'h1110;
  localparam logic [15:0] CLK_EN_MASK = 16'h00ff;
  localparam logic [15:0] STOP_DIS_MASK = 16'h00ff;
  localparam logic [15:0] HS_SEL_MASK = 16'h000f;
  // Reset values
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [15:0] CLK_EN_RESET = 16'h00ff;
  localparam logic [15:0] STOP_DIS_RESET = 16'h0000;
  localparam logic [15:0] HS_SEL_RESET = 16'h0000;
  // Field positions
  localparam int DAC0_SYNC_POS = 0;
  localparam int DAC1_SYNC_POS = 4;
  localparam int TA1_SEL_POS = 4;
  localparam int TA2_SEL_POS = 8;
  localparam int TA3_SEL_POS = 12;
  localparam int HS_PWM_POS = 0;
  localparam int HS_QUAD_TIMER_A_POS = 1;
  // DAC sync source codes
  localparam logic [2:0] SYNC_INTERVAL_TIMER0 = 3'h0;
  localparam logic [2:0] SYNC_INTERVAL_TIMER1 = 3'h1;
  localparam logic [2:0] SYNC_INTERVAL_TIMER2 = 3'h2;
  localparam logic [2:0] SYNC_PWM = 3'h3;
  localparam logic [2:0] SYNC_TA0 = 3'h4;
  localparam logic [2:0] SYNC_TA1 = 3'h5;
  // Peripheral counts
  localparam int NUM_PERIPH = 8;
  localparam int NUM_HS = 4;
  // Watchdog divide ratio
  localparam int WDOG_DIV = 1024;
  localparam logic [9:0] WDOG_LAST = 10'(WDOG_DIV - 1);
  // Oscillator model: sys_clk cycles per oscillator edge, normal and standby
  localparam logic [7:0] OSC_DIV = 8'h04;
  localparam logic [7:0] OSC_STBY_DIV = 8'h28;
  // Controller register byte offsets on AXI4-Lite
  localparam logic [3:0] CTL_ADDR_OFF = 4'h0;
  localparam logic [3:0] CTL_DATA_OFF = 4'h4;
  localparam logic [3:0] CTL_CLKCFG_OFF = 4'h8;
  localparam logic [3:0] CTL_CMD_OFF = 4'hc;
  localparam logic [4:0] CLKCFG_RESET = 5'h03;
  localparam int CFG_PLL_PWR = 0;
  localparam int CFG_PLL_SEL = 1;
  localparam int CFG_OSC_STBY = 2;
  localparam int CFG_OSC_PD = 3;
  localparam int CFG_LREG_STBY = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Power modes
  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP, MODE_POWERDOWN} scp_mode_e;
endpackage

//--- hw/scp_link_if.sv
// Link between the integration unit and its clock-source and core controller
`timescale 1ns/1ps
interface scp_link_if;
  logic regWrite;
  logic [7:0] regAddr;
  logic [15:0] regWrData;
  logic [15:0] regRdData;
  logic waitReq;
  logic stopReq;
  logic debugEntry;
  logic pllTick;
  logic oscTick;
  logic tripleTick;
  logic pllPowered;
  logic pllSelected;
  logic relaxOscStandby;
  logic relaxOscPowerDown;
  logic largeRegulatorStandby;
  logic [1:0] mode;
  logic standby;
  modport device (
    input regWrite, regAddr, regWrData, waitReq, stopReq, debugEntry,
    input pllTick, oscTick, tripleTick, pllPowered, pllSelected,
    input relaxOscStandby, relaxOscPowerDown, largeRegulatorStandby,
    output regRdData, mode, standby
  );
  modport ctrl (
    output regWrite, regAddr, regWrData, waitReq, stopReq, debugEntry,
    output pllTick, oscTick, tripleTick, pllPowered, pllSelected,
    output relaxOscStandby, relaxOscPowerDown, largeRegulatorStandby,
    input regRdData, mode, standby
  );
endinterface

//--- hw/scp_sim_unit.sv
// Integration unit: source selects, clock derivation and power modes
// What this block does
// - DAC1 sync field picks one of six sources
// - DAC0 sync field low bits, same coding
// - Timer A input 3: pin or PWM sync
// - Timer A input 2: pin or comparator B
// - Timer A input 1: pin or comparator A
// - Reserved bits written zero, read zero
// - PWM and Timer A share one clock rate
// - System clock is master clock halved, gated
// - Gated triple-rate clock for fast peripherals
// - PLL selected enables triple rate, else oscillator
// - Fast clocking only with PLL powered, selected
// - Per-peripheral clock enable stops its clock
// - Run keeps core, memory, peripheral clocks
// - Wait stops core; interrupt, debug, reset exit
// - Stop gates all; enabled wakeups exit
// - Stop-disable bit keeps peripheral clock in Stop
// - Standby set from PLL deselected, oscillator and regulator standby
// - Oscillator off in Standby: Power-Down, reset only
// - Wait or Stop allowed within Standby
// - Regulator standby only slow and PLL deselected
// - Watchdog ticks at oscillator over 1024
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module scp_sim_unit (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  scp_link_if.device link,
  input wire logic [2:0] intervalTimer,
  input wire logic pwmReloadSync,
  input wire logic [1:0] timerACh,
  input wire logic [3:1] timerAPin,
  input wire logic comparatorAOut,
  input wire logic comparatorBOut,
  input wire logic anyIrq,
  input wire logic [7:0] stopPeriphIrq,
  input wire logic lowVoltIrq,
  output logic [1:0] dacSync,
  output logic [3:1] timerAIn,
  output logic coreClkTick,
  output logic [7:0] periphClkTick,
  output logic [3:0] hsPeriphClkTick,
  output logic watchdogTick
);
  logic [15:0] dacSyncSel;
  logic [15:0] timerASel;
  logic [15:0] clkEn;
  logic [15:0] stopDis;
  logic [15:0] hsSel;
  logic [3:1] pinMeta;
  logic [3:1] pinSync;
  logic sysPhase;
  logic masterTick;
  logic sysTick;
  logic tripleOk;
  logic [9:0] wdogCnt;
  logic wakeStop;
  logic [15:0] next_rdData;
  scp_pkg::scp_mode_e mode;
  scp_pkg::scp_mode_e next_mode;

  // Register writes, reserved bits masked to zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dacSyncSel <= scp_pkg::SEL_RESET;
      timerASel <= scp_pkg::SEL_RESET;
      clkEn <= scp_pkg::CLK_EN_RESET;
      stopDis <= scp_pkg::STOP_DIS_RESET;
      hsSel <= scp_pkg::HS_SEL_RESET;
    end else if (ce && link.regWrite) begin
      case (link.regAddr)
        scp_pkg::DAC_SYNC_IDX: dacSyncSel <= link.regWrData & scp_pkg::DAC_SYNC_MASK;
        scp_pkg::TIMER_A_SEL_IDX: timerASel <= link.regWrData & scp_pkg::TIMER_A_SEL_MASK;
        scp_pkg::CLK_EN_IDX: clkEn <= link.regWrData & scp_pkg::CLK_EN_MASK;
        scp_pkg::STOP_DIS_IDX: stopDis <= link.regWrData & scp_pkg::STOP_DIS_MASK;
        scp_pkg::HS_SEL_IDX: hsSel <= link.regWrData & scp_pkg::HS_SEL_MASK;
        default: ;
      endcase
    end
  end

  // Read data follows the addressed register one cycle later
  always_comb begin
    case (link.regAddr)
      scp_pkg::DAC_SYNC_IDX: next_rdData = dacSyncSel;
      scp_pkg::TIMER_A_SEL_IDX: next_rdData = timerASel;
      scp_pkg::CLK_EN_IDX: next_rdData = clkEn;
      scp_pkg::STOP_DIS_IDX: next_rdData = stopDis;
      scp_pkg::HS_SEL_IDX: next_rdData = hsSel;
      scp_pkg::STATUS_IDX: next_rdData = {13'h0000, link.standby, mode};
      default: next_rdData = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.regRdData <= 16'h0000;
    end else if (ce) begin
      link.regRdData <= next_rdData;
    end
  end

  // Two-flop synchroniser for Timer A pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end else if (ce) begin
      pinMeta <= timerAPin;
      pinSync <= pinMeta;
    end
  end

  // DAC sync source multiplexers, one per DAC
  for (genvar d = 0; d < 2; d++) begin : gDacSync
    logic [2:0] code;
    assign code = dacSyncSel[d * scp_pkg::DAC1_SYNC_POS +: 3];
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        dacSync[d] <= 1'b0;
      end else if (ce) begin
        case (code)
          scp_pkg::SYNC_INTERVAL_TIMER0: dacSync[d] <= intervalTimer[0];
          scp_pkg::SYNC_INTERVAL_TIMER1: dacSync[d] <= intervalTimer[1];
          scp_pkg::SYNC_INTERVAL_TIMER2: dacSync[d] <= intervalTimer[2];
          scp_pkg::SYNC_PWM: dacSync[d] <= pwmReloadSync;
          scp_pkg::SYNC_TA0: dacSync[d] <= timerACh[0];
          scp_pkg::SYNC_TA1: dacSync[d] <= timerACh[1];
          default: dacSync[d] <= 1'b0;
        endcase
      end
    end
  end

  // Timer A input multiplexers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerAIn <= 3'h0;
    end else if (ce) begin
      timerAIn[1] <= timerASel[scp_pkg::TA1_SEL_POS] ? comparatorAOut : pinSync[1];
      timerAIn[2] <= timerASel[scp_pkg::TA2_SEL_POS] ? comparatorBOut : pinSync[2];
      timerAIn[3] <= timerASel[scp_pkg::TA3_SEL_POS] ? pwmReloadSync : pinSync[3];
    end
  end

  // Master clock source and triple-rate permission
  assign masterTick = link.pllSelected ? link.pllTick : link.oscTick;
  assign tripleOk = link.pllSelected && link.pllPowered;
  assign sysTick = masterTick && sysPhase;

  // Divide master clock by two
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysPhase <= 1'b0;
    end else if (ce && masterTick) begin
      sysPhase <= !sysPhase;
    end
  end

  // Wake sources for Stop: enabled peripherals, low voltage, debug
  assign wakeStop = |(stopPeriphIrq & stopDis[7:0]) || lowVoltIrq || link.debugEntry;

  // Power mode sequencing
  always_comb begin
    next_mode = mode;
    case (mode)
      scp_pkg::MODE_RUN: begin
        if (link.standby && link.relaxOscPowerDown) begin
          next_mode = scp_pkg::MODE_POWERDOWN;
        end else if (link.stopReq) begin
          next_mode = scp_pkg::MODE_STOP;
        end else if (link.waitReq) begin
          next_mode = scp_pkg::MODE_WAIT;
        end
      end
      scp_pkg::MODE_WAIT: begin
        if (anyIrq || link.debugEntry) begin
          next_mode = scp_pkg::MODE_RUN;
        end
      end
      scp_pkg::MODE_STOP: begin
        if (wakeStop) begin
          next_mode = scp_pkg::MODE_RUN;
        end
      end
      scp_pkg::MODE_POWERDOWN: next_mode = scp_pkg::MODE_POWERDOWN;
      default: next_mode = scp_pkg::MODE_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= scp_pkg::MODE_RUN;
      link.standby <= 1'b0;
    end else if (ce) begin
      mode <= next_mode;
      link.standby <= !link.pllSelected && link.relaxOscStandby
        && link.largeRegulatorStandby;
    end
  end
  assign link.mode = mode;

  // Core and memory clock runs only in Run
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreClkTick <= 1'b0;
    end else if (ce) begin
      coreClkTick <= sysTick && mode == scp_pkg::MODE_RUN;
    end
  end

  // Per-peripheral system and fast clocks
  for (genvar i = 0; i < scp_pkg::NUM_PERIPH; i++) begin : gPeriph
    logic run;
    assign run = clkEn[i] && (mode == scp_pkg::MODE_RUN || mode == scp_pkg::MODE_WAIT
      || (mode == scp_pkg::MODE_STOP && stopDis[i]));
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        periphClkTick[i] <= 1'b0;
      end else if (ce) begin
        periphClkTick[i] <= sysTick && run;
      end
    end
    if (i < scp_pkg::NUM_HS) begin : gHs
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          hsPeriphClkTick[i] <= 1'b0;
        end else if (ce) begin
          hsPeriphClkTick[i] <= link.tripleTick && tripleOk && hsSel[i] && run;
        end
      end
    end
  end

  // Watchdog tick from oscillator divided by 1024
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdogCnt <= 10'h000;
      watchdogTick <= 1'b0;
    end else if (ce) begin
      watchdogTick <= link.oscTick && wdogCnt == scp_pkg::WDOG_LAST;
      if (link.oscTick) begin
        wdogCnt <= wdogCnt + 10'h001;
      end
    end
  end
endmodule

//--- hw/scp_controller.sv
// Controller end: clock source model, core requests, AXI4-Lite registers
`timescale 1ns/1ps
module scp_controller (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  scp_link_if.ctrl link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  logic awHeld;
  logic wHeld;
  logic [3:0] awAddr;
  logic [31:0] wData;
  logic doWrite;
  logic [4:0] cfg;
  logic [4:0] next_cfg;
  logic [15:0] next_wrData;
  logic [7:0] oscCnt;
  logic [7:0] oscLast;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = ce && awHeld && wHeld && !s_axi_bvalid;

  // Address and data latches, taken in either order
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 4'h0;
      wData <= 32'h00000000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= scp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awAddr[1:0] != 2'h0 ? scp_pkg::RESP_SLVERR : scp_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Clock configuration kept to legal combinations
  always_comb begin
    next_cfg = wData[4:0];
    if (!next_cfg[scp_pkg::CFG_PLL_PWR]) begin
      next_cfg[scp_pkg::CFG_PLL_SEL] = 1'b0;
    end
    if (next_cfg[scp_pkg::CFG_PLL_SEL] || !next_cfg[scp_pkg::CFG_OSC_STBY]) begin
      next_cfg[scp_pkg::CFG_LREG_STBY] = 1'b0;
    end
    if (!next_cfg[scp_pkg::CFG_LREG_STBY] || next_cfg[scp_pkg::CFG_PLL_PWR]) begin
      next_cfg[scp_pkg::CFG_OSC_PD] = 1'b0;
    end
  end

  // Device register data, select-register reserved bits cleared and fast clocks guarded
  always_comb begin
    next_wrData = wData[15:0];
    case (link.regAddr)
      scp_pkg::DAC_SYNC_IDX: next_wrData = wData[15:0] & scp_pkg::DAC_SYNC_MASK;
      scp_pkg::TIMER_A_SEL_IDX: next_wrData = wData[15:0] & scp_pkg::TIMER_A_SEL_MASK;
      scp_pkg::HS_SEL_IDX: begin
        next_wrData = wData[15:0] & scp_pkg::HS_SEL_MASK;
        next_wrData[scp_pkg::HS_QUAD_TIMER_A_POS] = wData[scp_pkg::HS_PWM_POS];
        if (!(cfg[scp_pkg::CFG_PLL_SEL] && cfg[scp_pkg::CFG_PLL_PWR])) begin
          next_wrData = 16'h0000;
        end
      end
      default: ;
    endcase
  end

  // Register effects and one-cycle command pulses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.regAddr <= 8'h00;
      link.regWrData <= 16'h0000;
      link.regWrite <= 1'b0;
      link.waitReq <= 1'b0;
      link.stopReq <= 1'b0;
      link.debugEntry <= 1'b0;
      cfg <= scp_pkg::CLKCFG_RESET;
    end else if (ce) begin
      link.regWrite <= doWrite && awAddr == scp_pkg::CTL_DATA_OFF;
      link.waitReq <= doWrite && awAddr == scp_pkg::CTL_CMD_OFF && wData[0];
      link.stopReq <= doWrite && awAddr == scp_pkg::CTL_CMD_OFF && wData[1];
      link.debugEntry <= doWrite && awAddr == scp_pkg::CTL_CMD_OFF && wData[2];
      if (doWrite && awAddr == scp_pkg::CTL_ADDR_OFF) begin
        link.regAddr <= wData[7:0];
      end
      if (doWrite && awAddr == scp_pkg::CTL_DATA_OFF) begin
        link.regWrData <= next_wrData;
      end
      if (doWrite && awAddr == scp_pkg::CTL_CLKCFG_OFF) begin
        cfg <= next_cfg;
      end
    end
  end

  assign link.pllPowered = cfg[scp_pkg::CFG_PLL_PWR];
  assign link.pllSelected = cfg[scp_pkg::CFG_PLL_SEL];
  assign link.relaxOscStandby = cfg[scp_pkg::CFG_OSC_STBY];
  assign link.relaxOscPowerDown = cfg[scp_pkg::CFG_OSC_PD];
  assign link.largeRegulatorStandby = cfg[scp_pkg::CFG_LREG_STBY];
  assign oscLast = cfg[scp_pkg::CFG_OSC_STBY] ? scp_pkg::OSC_STBY_DIV : scp_pkg::OSC_DIV;

  // Oscillator, PLL and triple-rate tick model
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscCnt <= 8'h00;
      link.oscTick <= 1'b0;
      link.pllTick <= 1'b0;
      link.tripleTick <= 1'b0;
    end else if (ce) begin
      oscCnt <= oscCnt + 8'h01 >= oscLast ? 8'h00 : oscCnt + 8'h01;
      link.oscTick <= !cfg[scp_pkg::CFG_OSC_PD] && oscCnt == 8'h00;
      link.pllTick <= cfg[scp_pkg::CFG_PLL_PWR] && cfg[scp_pkg::CFG_PLL_SEL];
      link.tripleTick <= cfg[scp_pkg::CFG_PLL_PWR] && cfg[scp_pkg::CFG_PLL_SEL];
    end
  end

  // Read channel
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= scp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= s_axi_araddr[1:0] != 2'h0 ? scp_pkg::RESP_SLVERR : scp_pkg::RESP_OKAY;
        case (s_axi_araddr)
          scp_pkg::CTL_ADDR_OFF: s_axi_rdata <= {24'h000000, link.regAddr};
          scp_pkg::CTL_DATA_OFF: s_axi_rdata <= {16'h0000, link.regRdData};
          scp_pkg::CTL_CLKCFG_OFF: s_axi_rdata <= {27'h0000000, cfg};
          scp_pkg::CTL_CMD_OFF: s_axi_rdata <= {29'h00000000, link.standby, link.mode};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

//--- test/scp_props.sv
// Link assertions
`timescale 1ns/1ps
module scp_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic waitReq,
  input wire logic stopReq,
  input wire logic debugEntry,
  input wire logic tripleTick,
  input wire logic pllPowered,
  input wire logic pllSelected,
  input wire logic relaxOscPowerDown,
  input wire logic [1:0] mode,
  input wire logic standby
);
  // One clock, reset disables
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Mode transitions
  property p_wait_entry;
    mode == 2'h0 && waitReq && !stopReq && !(standby && relaxOscPowerDown) |=> mode == 2'h1;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait not entered");
  property p_stop_entry;
    mode == 2'h0 && stopReq && !(standby && relaxOscPowerDown) |=> mode == 2'h2;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");
  property p_wait_exit;
    mode == 2'h1 && debugEntry |=> mode == 2'h0;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("wait not left");
  property p_stop_exit;
    mode == 2'h2 && debugEntry |=> mode == 2'h0;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stop not left");
  property p_pd_entry;
    mode == 2'h0 && standby && relaxOscPowerDown |=> mode == 2'h3;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");
  property p_pd_hold;
    mode == 2'h3 |=> mode == 2'h3;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down left");
  // PLL interlocks
  property p_triple_off;
    !pllSelected [*2] |-> !tripleTick;
  endproperty
  a_triple_off: assert property (p_triple_off) else $error("triple tick without pll");
  property p_pll_sel;
    pllSelected |-> pllPowered;
  endproperty
  a_pll_sel: assert property (p_pll_sel) else $error("pll selected unpowered");
  // Masked select readback
  property p_tmr_mask;
    regWrite && regAddr == scp_pkg::TIMER_A_SEL_IDX ##1 regAddr == scp_pkg::TIMER_A_SEL_IDX
      |=> regRdData == ($past(regWrData, 2) & scp_pkg::TIMER_A_SEL_MASK);
  endproperty
  a_tmr_mask: assert property (p_tmr_mask) else $error("select readback wrong");
endmodule

//--- test/sim_clock_power_source_select_tb.sv
// Bench for both ends over AXI4-Lite
`timescale 1ns/1ps
module sim_clock_power_source_select_tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] srcVec = 8'h00;
  logic [3:1] timerAPin = 3'h0;
  logic [9:0] wakeVec = 10'h000;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, dacSync;
  logic [31:0] s_axi_rdata;
  logic [3:1] timerAIn;
  logic coreClkTick, watchdogTick;
  logic [7:0] periphClkTick;
  logic [3:0] hsPeriphClkTick;
  int n_mismatch = 0, checked = 0, i, k, n;
  logic [2:0] s;
  logic [15:0] rstVal [6] = '{16'h0, 16'h0, scp_pkg::CLK_EN_RESET, 16'h0, 16'h0, 16'h0};
  logic [7:0] mIdx [3] = '{scp_pkg::DAC_SYNC_IDX, scp_pkg::TIMER_A_SEL_IDX, 8'h1f};
  logic [15:0] mExp [3] = '{16'h0077, 16'h1110, 16'h0};
  logic [31:0] enterCmd [6] = '{32'h1, 32'h1, 32'h2, 32'h2, 32'h2, 32'h2};
  logic [9:0] wakeSet [6] = '{10'h0, 10'h100, 10'h0, 10'h001, 10'h200, 10'h002};

  scp_link_if link ();
  scp_controller u_scp_controller (
    .sys_clk, .rst_n, .ce(1'b1), .link,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp
  );
  scp_sim_unit u_scp_sim_unit (
    .sys_clk, .rst_n, .ce(1'b1), .link,
    .intervalTimer(srcVec[2:0]), .pwmReloadSync(srcVec[3]), .timerACh(srcVec[5:4]),
    .timerAPin, .comparatorAOut(srcVec[6]), .comparatorBOut(srcVec[7]),
    .anyIrq(wakeVec[8]), .stopPeriphIrq(wakeVec[7:0]), .lowVoltIrq(wakeVec[9]),
    .dacSync, .timerAIn, .coreClkTick, .periphClkTick, .hsPeriphClkTick, .watchdogTick
  );
  scp_props u_scp_props (
    .sys_clk, .rst_n, .regWrite(link.regWrite), .regAddr(link.regAddr),
    .regWrData(link.regWrData), .regRdData(link.regRdData), .waitReq(link.waitReq),
    .stopReq(link.stopReq), .debugEntry(link.debugEntry), .tripleTick(link.tripleTick),
    .pllPowered(link.pllPowered), .pllSelected(link.pllSelected),
    .relaxOscPowerDown(link.relaxOscPowerDown), .mode(link.mode), .standby(link.standby)
  );

  // 100 MHz clock
  initial forever #5 sys_clk = ~sys_clk;

  // Verdict and end of run
  task automatic final_report();
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic timeout();
    n_mismatch++;
    $display("Error at %0t: no answer", $time);
    final_report();
  endtask

  task automatic check(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  // AXI4-Lite write
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic done;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    for (int t = 0; t < 50 && !done; t++) begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      done = (s_axi_bvalid === 1'b1);
    end
    s_axi_bready <= 1'b0;
    if (!done)
      timeout();
    check({30'h0, s_axi_bresp}, 32'h0);
  endtask

  // AXI4-Lite read
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    logic done;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    for (int t = 0; t < 50 && !done; t++) begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      done = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
    end
    s_axi_rready <= 1'b0;
    if (!done)
      timeout();
  endtask

  task automatic ctl_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_read(a, d);
    check(d, exp);
  endtask

  // Device register access
  task automatic dev_write(input logic [7:0] idx, input logic [15:0] v);
    axi_write(scp_pkg::CTL_ADDR_OFF, {24'h0, idx});
    axi_write(scp_pkg::CTL_DATA_OFF, {16'h0, v});
  endtask

  task automatic dev_chk(input logic [7:0] idx, input logic [15:0] exp);
    axi_write(scp_pkg::CTL_ADDR_OFF, {24'h0, idx});
    ctl_chk(scp_pkg::CTL_DATA_OFF, {16'h0, exp});
  endtask

  // Ticks in 64 cycles: core, periph 0 and 1, fast 0
  task automatic ticks(input logic [31:0] exp);
    logic [31:0] c;
    c = 32'h0;
    for (int t = 0; t < 64; t++) begin
      @(posedge sys_clk);
      c = c + {8'(coreClkTick), 8'(periphClkTick[0]), 8'(periphClkTick[1]),
        8'(hsPeriphClkTick[0])};
    end
    check(c, exp);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++)
      dev_chk(8'(scp_pkg::DAC_SYNC_IDX + i), rstVal[i]);
    for (i = 0; i < 3; i++) begin
      dev_write(mIdx[i], 16'hffff);
      dev_chk(mIdx[i], mExp[i]);
    end
    // DAC1 gets code i, DAC0 the inverse code
    for (i = 0; i < 8; i++) begin
      s = 3'(i);
      dev_write(scp_pkg::DAC_SYNC_IDX, {9'h0, s, 1'b0, ~s});
      for (k = 0; k < 2; k++) begin
        srcVec <= (k == 0) ? 8'(1 << i) : ~8'(1 << i);
        repeat (3) @(posedge sys_clk);
        check({30'h0, dacSync}, {30'h0, k == 0 && i < 6, k == 1 && i > 1});
      end
    end
    timerAPin <= 3'b010;
    srcVec <= 8'h48;
    for (i = 0; i < 8; i++) begin
      s = 3'(i);
      dev_write(scp_pkg::TIMER_A_SEL_IDX, {3'h0, s[2], 3'h0, s[1], 3'h0, s[0], 4'h0});
      repeat (4) @(posedge sys_clk);
      check({29'h0, timerAIn}, {29'h0, (s & 3'b101) | (~s & 3'b010)});
    end
    for (n = 0; n < 9000 && watchdogTick !== 1'b1; n++)
      @(posedge sys_clk);
    @(posedge sys_clk);
    for (n = 1; n < 9000 && watchdogTick !== 1'b1; n++)
      @(posedge sys_clk);
    check(n, scp_pkg::WDOG_DIV * int'(scp_pkg::OSC_DIV));
    ticks(32'h20202000);
    dev_write(scp_pkg::STOP_DIS_IDX, 16'h0001);
    for (i = 0; i < 6; i++) begin
      axi_write(scp_pkg::CTL_CMD_OFF, enterCmd[i]);
      ctl_chk(scp_pkg::CTL_CMD_OFF, enterCmd[i]);
      ticks(i < 2 ? 32'h00202000 : 32'h00200000);
      if (wakeSet[i] == 10'h0)
        axi_write(scp_pkg::CTL_CMD_OFF, 32'h4);
      else begin
        @(posedge sys_clk);
        wakeVec <= wakeSet[i];
        @(posedge sys_clk);
        wakeVec <= 10'h0;
      end
      ctl_chk(scp_pkg::CTL_CMD_OFF, i == 5 ? 32'h2 : 32'h0);
    end
    axi_write(scp_pkg::CTL_CMD_OFF, 32'h4);
    dev_write(scp_pkg::HS_SEL_IDX, 16'h0001);
    dev_chk(scp_pkg::HS_SEL_IDX, 16'h0003);
    ticks(32'h20202040);
    dev_write(scp_pkg::CLK_EN_IDX, 16'h00fd);
    ticks(32'h20200040);
    dev_write(scp_pkg::CLK_EN_IDX, 16'h00ff);
    axi_write(scp_pkg::CTL_CLKCFG_OFF, 32'h13);
    ctl_chk(scp_pkg::CTL_CLKCFG_OFF, 32'h3);
    axi_write(scp_pkg::CTL_CLKCFG_OFF, 32'h1);
    ticks(32'h08080800);
    dev_write(scp_pkg::HS_SEL_IDX, 16'h0001);
    dev_chk(scp_pkg::HS_SEL_IDX, 16'h0000);
    axi_write(scp_pkg::CTL_CLKCFG_OFF, 32'h2);
    axi_write(scp_pkg::CTL_CLKCFG_OFF, 32'h4);
    axi_write(scp_pkg::CTL_CLKCFG_OFF, 32'h14);
    ctl_chk(scp_pkg::CTL_CLKCFG_OFF, 32'h14);
    ctl_chk(scp_pkg::CTL_CMD_OFF, 32'h4);
    axi_write(scp_pkg::CTL_CMD_OFF, 32'h1);
    ctl_chk(scp_pkg::CTL_CMD_OFF, 32'h5);
    axi_write(scp_pkg::CTL_CMD_OFF, 32'h4);
    axi_write(scp_pkg::CTL_CLKCFG_OFF, 32'h1c);
    ctl_chk(scp_pkg::CTL_CMD_OFF, 32'h7);
    ticks(32'h0);
    axi_write(scp_pkg::CTL_CMD_OFF, 32'h4);
    ctl_chk(scp_pkg::CTL_CMD_OFF, 32'h7);
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    ctl_chk(scp_pkg::CTL_CMD_OFF, 32'h0);
    final_report();
  end
endmodule
